// ===== core/pfm_defs.svh
`ifndef PFM_DEFS_SVH
`define PFM_DEFS_SVH
// pad configuration, control and status register byte addresses
`define PFM_ADDR_PIN3 32'h4402e0c8
`define PFM_ADDR_PIN4 32'h4402e0cc
`define PFM_ADDR_PIN9 32'h4402e0d0
`define PFM_ADDR_PIN10 32'h4402e0d4
`define PFM_ADDR_PIN5 32'h4402e0d8
`define PFM_ADDR_PIN6 32'h4402e0dc
`define PFM_ADDR_PIN7 32'h4402e0e0
`define PFM_ADDR_PIN8 32'h4402e0e4
`define PFM_ADDR_PIN11 32'h4402e0f8
`define PFM_ADDR_TEST_IN 32'h4402e0fc
`define PFM_ADDR_TEST_OUT 32'h4402e100
`define PFM_ADDR_CTRL 32'h4402e180
`define PFM_ADDR_STATUS 32'h4402e184
// pad slot numbers
`define PFM_IX_P3 4'h0
`define PFM_IX_P4 4'h1
`define PFM_IX_P9 4'h2
`define PFM_IX_P10 4'h3
`define PFM_IX_P5 4'h4
`define PFM_IX_P6 4'h5
`define PFM_IX_P7 4'h6
`define PFM_IX_P8 4'h7
`define PFM_IX_P11 4'h8
`define PFM_IX_TDI 4'h9
`define PFM_IX_TDO 4'ha
`define PFM_IX_NONE 4'hf
`define PFM_NUM_PADS 11
// fields, reset values, timing
`define PFM_CFG_WMASK 12'hf3f
`define PFM_CFG_RESET_GP 12'h00f
`define PFM_CFG_RESET_JTAG 12'h001
`define PFM_MODE_RESET_HIZ 4'hf
`define PFM_DRV_6MA 2'h2
`define PFM_DRV_RSVD 2'h3
`define PFM_F_PULL_UP 8
`define PFM_CTRL_SWD 0
`define PFM_STRAP_WAIT 2'h3
// mode values
`define PFM_MODE_GPIO 4'h0
`define PFM_P3_SCL 4'h1
`define PFM_P3_PWM 4'h3
`define PFM_P3_SDCLK 4'h6
`define PFM_P3_UTX 4'h7
`define PFM_P3_CAP 4'hc
`define PFM_P4_SDA 4'h1
`define PFM_P4_PWM 4'h3
`define PFM_P4_CAMCLK 4'h4
`define PFM_P4_SDCMD 4'h6
`define PFM_P4_URX 4'h7
`define PFM_P4_CAP 4'hc
`define PFM_P4_AFS 4'hd
`define PFM_P5_CAM 4'h4
`define PFM_P5_SCL 4'h5
`define PFM_P5_SPICLK 4'h7
`define PFM_P5_CAP 4'hc
`define PFM_P6_CAM 4'h4
`define PFM_P6_SDA 4'h5
`define PFM_P6_MISO 4'h7
`define PFM_P6_SDD0 4'h8
`define PFM_P6_CAP 4'hd
`define PFM_P7_CAM 4'h4
`define PFM_P7_UTX 4'h5
`define PFM_P7_MOSI 4'h7
`define PFM_P7_SDCLK 4'h8
`define PFM_P7_CAP 4'hd
`define PFM_P8_CAM 4'h4
`define PFM_P8_URX 4'h5
`define PFM_P8_CS 4'h7
`define PFM_P8_SDCMD 4'h8
`define PFM_P9_ACLK 4'h3
`define PFM_P9_VS 4'h4
`define PFM_P9_SCL 4'h5
`define PFM_P9_UTX 4'h7
`define PFM_P9_CAP 4'hc
`define PFM_P10_HS 4'h4
`define PFM_P10_SDA 4'h5
`define PFM_P10_URX 4'h7
`define PFM_P10_CAP 4'hc
`define PFM_P11_CAP 4'h5
`define PFM_P11_AFS 4'h7
`define PFM_TDI_TDI 4'h1
`define PFM_TDI_UTX 4'h2
`define PFM_TDI_SCL 4'h9
`define PFM_TDO_TDO 4'h1
`define PFM_TDO_URX 4'h2
`define PFM_TDO_CAP 4'h4
`define PFM_TDO_PWM 4'h5
`define PFM_TDO_SDA 4'h9
`endif

// ===== core/pfm_pkg.sv
package pfm_pkg;
  typedef struct packed {
    logic hib_lvl;
    logic hib_en;
    logic pull_down;
    logic pull_up;
    logic [1:0] rsv;
    logic [1:0] drive;
    logic [3:0] mode;
  } pfm_cfg_s;
  typedef struct packed {
    logic [1:0] drive;
    logic pull_up;
    logic pull_down;
  } pfm_pad_cfg_s;
  typedef struct packed {
    logic oe;
    logic out;
  } pfm_drv_s;
  typedef struct packed {
    logic [10:0] gpio_out;
    logic [10:0] gpio_oe;
    logic scl_low, sda_low;
    logic pwm_out_six, pwm_out_seven, pwm_out_zero;
    logic sd_clock, sd_command_out, sd_command_oe, sd_data_zero_out, sd_data_zero_oe;
    logic first_uart_transmit, second_uart_transmit;
    logic camera_free_clock, audio_port_clock, audio_frame_sync;
    logic spi_clock_out, spi_clock_oe, spi_miso_out, spi_miso_oe;
    logic spi_mosi_out, spi_mosi_oe, spi_select_out, spi_select_oe;
    logic test_data_out;
  } pfm_periph_out_s;
  typedef struct packed {
    logic [10:0] gpio_in;
    logic scl_in, sda_in;
    logic [7:1] capture_in;
    logic first_uart_receive, second_uart_receive;
    logic sd_command_in, sd_data_zero_in;
    logic [7:4] camera_data;
    logic camera_vertical_sync, camera_horizontal_sync;
    logic spi_clock_in, spi_miso_in, spi_mosi_in, spi_select_in;
    logic test_data_in;
  } pfm_periph_in_s;
endpackage

// ===== core/pfm_pad_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfm_defs.svh"
// Contract
// - function from reset strap plus register
// - per-pad drive of 2, 4, 6 mA
// - per-pad pull-up and pull-down select
// - pads other than test-out float in hibernate unless programmed
// - general pads stay hi-z after reset
// - boot leaves jtag, flash set; rest hi-z
// - pin 3 mode table
// - pin 4 mode table
// - pin 5 mode table
// - pin 6 mode table
// - pin 7 mode table
// - pin 8 mode table
// - pin 9 mode table
// - pin 10 mode table
// - pin 11 mode table
// - test-in pad resets to mode 1
// - test-out pad resets to mode 1
// - test-out in hibernate: high two-wire, else low
// - deep sleep holds flash select, tx high, sd and camera clocks low
// - flash pads fixed, hi-z in reset
module pfm_pad_mux
  import pfm_pkg::*;
(
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // power state, same clock
  input wire logic LOW_POWER_DEEP_SLEEP,
  input wire logic HIB_MODE,
  // debug two-wire strap pin
  input wire logic DEBUG_STRAP,
  // peripheral side
  input wire pfm_periph_out_s PERIPH_OUT,
  output var pfm_periph_in_s PERIPH_IN,
  input wire logic FLASH_CLK,
  input wire logic FLASH_MOSI,
  input wire logic SERIAL_FLASH_SELECT_N,
  output logic FLASH_MISO,
  // pad side
  input wire logic [10:0] PAD_IN,
  output logic [10:0] PAD_OUT,
  output logic [10:0] PAD_OE,
  output var pfm_pad_cfg_s [10:0] PAD_CFG,
  output logic [2:0] FLASH_PAD_OUT,
  output logic [2:0] FLASH_PAD_OE,
  input wire logic FLASH_PAD_MISO
);

  pfm_cfg_s cfg_ff [`PFM_NUM_PADS];
  logic [12:0] s1_ff, s2_ff, s3_ff, pin_ff;
  logic [12:0] nxt_pin;
  logic [10:0] out_ff, oe_ff, nxt_out, nxt_oe;
  logic [2:0] fout_ff, foe_ff;
  logic swd_ff, strap_ff, taken_ff;
  logic [1:0] wait_ff;
  logic [31:0] prdata_ff, rdata;
  pfm_periph_in_s pi_ff, nxt_pi;

  function automatic pfm_drv_s drv(input logic v);
    return '{oe: 1'b1, out: v};
  endfunction

  function automatic pfm_drv_s od(input logic low);
    return '{oe: low, out: 1'b0};
  endfunction

  function automatic pfm_drv_s io(input logic en, input logic v);
    return '{oe: en, out: v};
  endfunction

  function automatic logic [3:0] pfm_index(input logic [31:0] a);
    case (a)
      `PFM_ADDR_PIN3: return `PFM_IX_P3;
      `PFM_ADDR_PIN4: return `PFM_IX_P4;
      `PFM_ADDR_PIN9: return `PFM_IX_P9;
      `PFM_ADDR_PIN10: return `PFM_IX_P10;
      `PFM_ADDR_PIN5: return `PFM_IX_P5;
      `PFM_ADDR_PIN6: return `PFM_IX_P6;
      `PFM_ADDR_PIN7: return `PFM_IX_P7;
      `PFM_ADDR_PIN8: return `PFM_IX_P8;
      `PFM_ADDR_PIN11: return `PFM_IX_P11;
      `PFM_ADDR_TEST_IN: return `PFM_IX_TDI;
      `PFM_ADDR_TEST_OUT: return `PFM_IX_TDO;
      default: return `PFM_IX_NONE;
    endcase
  endfunction

  // reserved code 3 lands on the strongest setting
  function automatic pfm_cfg_s wcfg(input pfm_cfg_s old, input logic [31:0] wd,
                                    input logic [3:0] strb);
    logic [11:0] v;
    pfm_cfg_s r;
    v = old;
    if (strb[0]) begin
      v[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      v[11:8] = wd[11:8];
    end
    r = v & `PFM_CFG_WMASK;
    if (r.drive == `PFM_DRV_RSVD) begin
      r.drive = `PFM_DRV_6MA;
    end
    return r;
  endfunction

  // outgoing routing per pad and mode; input-only and unlisted modes float
  function automatic pfm_drv_s route(input logic [3:0] p, input logic [3:0] m,
                                     input pfm_periph_out_s o);
    pfm_drv_s d;
    d = '0;
    if (m == `PFM_MODE_GPIO) begin
      d = io(o.gpio_oe[p], o.gpio_out[p]);
    end else begin
      case (p)
        `PFM_IX_P3: case (m)
          `PFM_P3_SCL: d = od(o.scl_low);
          `PFM_P3_PWM: d = drv(o.pwm_out_six);
          `PFM_P3_SDCLK: d = drv(o.sd_clock);
          `PFM_P3_UTX: d = drv(o.second_uart_transmit);
          default: d = '0;
        endcase
        `PFM_IX_P4: case (m)
          `PFM_P4_SDA: d = od(o.sda_low);
          `PFM_P4_PWM: d = drv(o.pwm_out_seven);
          `PFM_P4_CAMCLK: d = drv(o.camera_free_clock);
          `PFM_P4_SDCMD: d = io(o.sd_command_oe, o.sd_command_out);
          `PFM_P4_AFS: d = drv(o.audio_frame_sync);
          default: d = '0;
        endcase
        `PFM_IX_P5: case (m)
          `PFM_P5_SCL: d = od(o.scl_low);
          `PFM_P5_SPICLK: d = io(o.spi_clock_oe, o.spi_clock_out);
          default: d = '0;
        endcase
        `PFM_IX_P6: case (m)
          `PFM_P6_SDA: d = od(o.sda_low);
          `PFM_P6_MISO: d = io(o.spi_miso_oe, o.spi_miso_out);
          `PFM_P6_SDD0: d = io(o.sd_data_zero_oe, o.sd_data_zero_out);
          default: d = '0;
        endcase
        `PFM_IX_P7: case (m)
          `PFM_P7_UTX: d = drv(o.second_uart_transmit);
          `PFM_P7_MOSI: d = io(o.spi_mosi_oe, o.spi_mosi_out);
          `PFM_P7_SDCLK: d = drv(o.sd_clock);
          default: d = '0;
        endcase
        `PFM_IX_P8: case (m)
          `PFM_P8_CS: d = io(o.spi_select_oe, o.spi_select_out);
          `PFM_P8_SDCMD: d = io(o.sd_command_oe, o.sd_command_out);
          default: d = '0;
        endcase
        `PFM_IX_P9: case (m)
          `PFM_P9_ACLK: d = drv(o.audio_port_clock);
          `PFM_P9_SCL: d = od(o.scl_low);
          `PFM_P9_UTX: d = drv(o.first_uart_transmit);
          default: d = '0;
        endcase
        `PFM_IX_P10: case (m)
          `PFM_P10_SDA: d = od(o.sda_low);
          default: d = '0;
        endcase
        `PFM_IX_P11: case (m)
          `PFM_P11_AFS: d = drv(o.audio_frame_sync);
          default: d = '0;
        endcase
        `PFM_IX_TDI: case (m)
          `PFM_TDI_UTX: d = drv(o.second_uart_transmit);
          `PFM_TDI_SCL: d = od(o.scl_low);
          default: d = '0;
        endcase
        `PFM_IX_TDO: case (m)
          `PFM_TDO_TDO: d = drv(o.test_data_out);
          `PFM_TDO_PWM: d = drv(o.pwm_out_zero);
          `PFM_TDO_SDA: d = od(o.sda_low);
          default: d = '0;
        endcase
        default: d = '0;
      endcase
    end
    return d;
  endfunction

  // deep-sleep hold levels; oe marks a forced pad
  function automatic pfm_drv_s low_power_deep_sleep_hold(input logic [3:0] p, input logic [3:0] m);
    logic tx1, clk0;
    tx1 = (p == `PFM_IX_P3 && m == `PFM_P3_UTX) || (p == `PFM_IX_P7 && m == `PFM_P7_UTX) ||
          (p == `PFM_IX_P9 && m == `PFM_P9_UTX) || (p == `PFM_IX_TDI && m == `PFM_TDI_UTX);
    clk0 = (p == `PFM_IX_P3 && m == `PFM_P3_SDCLK) || (p == `PFM_IX_P4 && m == `PFM_P4_CAMCLK) ||
           (p == `PFM_IX_P7 && m == `PFM_P7_SDCLK);
    return '{oe: tx1 | clk0, out: tx1};
  endfunction

  function automatic logic hit(input logic [3:0] mode, input logic pin, input logic [3:0] m);
    return (mode == m) & pin;
  endfunction

  function automatic logic low(input logic [3:0] mode, input logic pin, input logic [3:0] m);
    return (mode == m) & ~pin;
  endfunction

  // apb decode
  wire [3:0] widx = pfm_index(PADDR);
  wire is_ctrl = PADDR == `PFM_ADDR_CTRL;
  wire is_stat = PADDR == `PFM_ADDR_STATUS;
  wire mapped = (widx != `PFM_IX_NONE) | is_ctrl | is_stat;
  wire setup = PSEL & ~PENABLE;
  wire wr = PSEL & PENABLE & PWRITE & CE;
  wire ctrl_wr = wr & is_ctrl & PSTRB[0];
  wire strap_load = ~taken_ff & (wait_ff == `PFM_STRAP_WAIT);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA = prdata_ff;

  always_comb begin
    rdata = 32'h0;
    if (widx != `PFM_IX_NONE) begin
      rdata = {20'h0, cfg_ff[widx]};
    end else if (is_ctrl) begin
      rdata = {31'h0, swd_ff};
    end else if (is_stat) begin
      rdata = {29'h0, HIB_MODE, LOW_POWER_DEEP_SLEEP, strap_ff};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      prdata_ff <= 32'h0;
    end else if (CE && setup && !PWRITE) begin
      prdata_ff <= rdata;
    end
  end

  // reset leaves jtag pads in mode 1, all others floating
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      for (int i = 0; i < `PFM_NUM_PADS; i++) begin
        cfg_ff[i] <= (i == `PFM_IX_TDI || i == `PFM_IX_TDO) ?
                     `PFM_CFG_RESET_JTAG : `PFM_CFG_RESET_GP;
      end
    end else if (wr && widx != `PFM_IX_NONE) begin
      cfg_ff[widx] <= wcfg(cfg_ff[widx], PWDATA, PSTRB);
    end
  end

  // strap caught once the pin synchroniser has settled after reset
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wait_ff <= 2'h0;
      taken_ff <= 1'b0;
      strap_ff <= 1'b0;
      swd_ff <= 1'b0;
    end else if (CE) begin
      if (!taken_ff && wait_ff != `PFM_STRAP_WAIT) begin
        wait_ff <= wait_ff + 2'h1;
      end
      // pin_ff still holds its reset value at this edge; stages two and three agree already
      if (strap_load) begin
        taken_ff <= 1'b1;
        strap_ff <= nxt_pin[12];
      end
      if (ctrl_wr) begin
        swd_ff <= PWDATA[`PFM_CTRL_SWD];
      end else if (strap_load) begin
        swd_ff <= nxt_pin[12];
      end
    end
  end

  // pin synchronisers: a level counts once stages two and three agree
  assign nxt_pin = (s2_ff & s3_ff) | (pin_ff & (s2_ff ^ s3_ff));
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s1_ff <= 13'h0;
      s2_ff <= 13'h0;
      s3_ff <= 13'h0;
      pin_ff <= 13'h0;
    end else if (CE) begin
      s1_ff <= {DEBUG_STRAP, FLASH_PAD_MISO, PAD_IN};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= nxt_pin;
    end
  end

  // several pads on one input are simply or-ed, the uart receivers and-ed; choosing sanely is up to software
  always_comb begin
    nxt_pi = '0;
    for (int i = 0; i < `PFM_NUM_PADS; i++) begin
      nxt_pi.gpio_in[i] = hit(cfg_ff[i].mode, pin_ff[i], `PFM_MODE_GPIO);
    end
    nxt_pi.scl_in = hit(cfg_ff[`PFM_IX_P3].mode, pin_ff[`PFM_IX_P3], `PFM_P3_SCL) |
                    hit(cfg_ff[`PFM_IX_P5].mode, pin_ff[`PFM_IX_P5], `PFM_P5_SCL) |
                    hit(cfg_ff[`PFM_IX_P9].mode, pin_ff[`PFM_IX_P9], `PFM_P9_SCL) |
                    hit(cfg_ff[`PFM_IX_TDI].mode, pin_ff[`PFM_IX_TDI], `PFM_TDI_SCL);
    nxt_pi.sda_in = hit(cfg_ff[`PFM_IX_P4].mode, pin_ff[`PFM_IX_P4], `PFM_P4_SDA) |
                    hit(cfg_ff[`PFM_IX_P6].mode, pin_ff[`PFM_IX_P6], `PFM_P6_SDA) |
                    hit(cfg_ff[`PFM_IX_P10].mode, pin_ff[`PFM_IX_P10], `PFM_P10_SDA) |
                    hit(cfg_ff[`PFM_IX_TDO].mode, pin_ff[`PFM_IX_TDO], `PFM_TDO_SDA);
    nxt_pi.capture_in[1] = hit(cfg_ff[`PFM_IX_P3].mode, pin_ff[`PFM_IX_P3], `PFM_P3_CAP);
    nxt_pi.capture_in[2] = hit(cfg_ff[`PFM_IX_P4].mode, pin_ff[`PFM_IX_P4], `PFM_P4_CAP);
    nxt_pi.capture_in[3] = hit(cfg_ff[`PFM_IX_P9].mode, pin_ff[`PFM_IX_P9], `PFM_P9_CAP);
    nxt_pi.capture_in[4] = hit(cfg_ff[`PFM_IX_P10].mode, pin_ff[`PFM_IX_P10], `PFM_P10_CAP) |
                           hit(cfg_ff[`PFM_IX_P11].mode, pin_ff[`PFM_IX_P11], `PFM_P11_CAP);
    nxt_pi.capture_in[5] = hit(cfg_ff[`PFM_IX_P5].mode, pin_ff[`PFM_IX_P5], `PFM_P5_CAP);
    nxt_pi.capture_in[6] = hit(cfg_ff[`PFM_IX_P6].mode, pin_ff[`PFM_IX_P6], `PFM_P6_CAP) |
                           hit(cfg_ff[`PFM_IX_TDO].mode, pin_ff[`PFM_IX_TDO], `PFM_TDO_CAP);
    nxt_pi.capture_in[7] = hit(cfg_ff[`PFM_IX_P7].mode, pin_ff[`PFM_IX_P7], `PFM_P7_CAP);
    // receivers idle high when no pad feeds them
    nxt_pi.first_uart_receive = ~low(cfg_ff[`PFM_IX_P10].mode, pin_ff[`PFM_IX_P10], `PFM_P10_URX);
    nxt_pi.second_uart_receive = ~(low(cfg_ff[`PFM_IX_P4].mode, pin_ff[`PFM_IX_P4], `PFM_P4_URX) |
                                   low(cfg_ff[`PFM_IX_P8].mode, pin_ff[`PFM_IX_P8], `PFM_P8_URX) |
                                   low(cfg_ff[`PFM_IX_TDO].mode, pin_ff[`PFM_IX_TDO], `PFM_TDO_URX));
    nxt_pi.sd_command_in = hit(cfg_ff[`PFM_IX_P4].mode, pin_ff[`PFM_IX_P4], `PFM_P4_SDCMD) |
                           hit(cfg_ff[`PFM_IX_P8].mode, pin_ff[`PFM_IX_P8], `PFM_P8_SDCMD);
    nxt_pi.sd_data_zero_in = hit(cfg_ff[`PFM_IX_P6].mode, pin_ff[`PFM_IX_P6], `PFM_P6_SDD0);
    nxt_pi.camera_data[4] = hit(cfg_ff[`PFM_IX_P5].mode, pin_ff[`PFM_IX_P5], `PFM_P5_CAM);
    nxt_pi.camera_data[5] = hit(cfg_ff[`PFM_IX_P6].mode, pin_ff[`PFM_IX_P6], `PFM_P6_CAM);
    nxt_pi.camera_data[6] = hit(cfg_ff[`PFM_IX_P7].mode, pin_ff[`PFM_IX_P7], `PFM_P7_CAM);
    nxt_pi.camera_data[7] = hit(cfg_ff[`PFM_IX_P8].mode, pin_ff[`PFM_IX_P8], `PFM_P8_CAM);
    nxt_pi.camera_vertical_sync = hit(cfg_ff[`PFM_IX_P9].mode, pin_ff[`PFM_IX_P9], `PFM_P9_VS);
    nxt_pi.camera_horizontal_sync = hit(cfg_ff[`PFM_IX_P10].mode, pin_ff[`PFM_IX_P10],
                                        `PFM_P10_HS);
    nxt_pi.spi_clock_in = hit(cfg_ff[`PFM_IX_P5].mode, pin_ff[`PFM_IX_P5], `PFM_P5_SPICLK);
    nxt_pi.spi_miso_in = hit(cfg_ff[`PFM_IX_P6].mode, pin_ff[`PFM_IX_P6], `PFM_P6_MISO);
    nxt_pi.spi_mosi_in = hit(cfg_ff[`PFM_IX_P7].mode, pin_ff[`PFM_IX_P7], `PFM_P7_MOSI);
    nxt_pi.spi_select_in = hit(cfg_ff[`PFM_IX_P8].mode, pin_ff[`PFM_IX_P8], `PFM_P8_CS);
    nxt_pi.test_data_in = hit(cfg_ff[`PFM_IX_TDI].mode, pin_ff[`PFM_IX_TDI], `PFM_TDI_TDI);
  end

  // pad drive: hibernate first, then deep-sleep holds, then normal routing
  always_comb begin
    pfm_drv_s rt;
    pfm_drv_s lp;
    rt = '0;
    lp = '0;
    nxt_oe = 11'h0;
    nxt_out = 11'h0;
    for (int i = 0; i < `PFM_NUM_PADS; i++) begin
      rt = route(4'(i), cfg_ff[i].mode, PERIPH_OUT);
      lp = low_power_deep_sleep_hold(4'(i), cfg_ff[i].mode);
      if (HIB_MODE) begin
        if (i == `PFM_IX_TDO) begin
          nxt_oe[i] = 1'b1;
          nxt_out[i] = swd_ff;
        end else begin
          nxt_oe[i] = cfg_ff[i].hib_en;
          nxt_out[i] = cfg_ff[i].hib_en & cfg_ff[i].hib_lvl;
        end
      end else if (LOW_POWER_DEEP_SLEEP && lp.oe) begin
        nxt_oe[i] = 1'b1;
        nxt_out[i] = lp.out;
      end else begin
        nxt_oe[i] = rt.oe;
        nxt_out[i] = rt.out;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      oe_ff <= 11'h0;
      out_ff <= 11'h0;
      pi_ff <= '0;
    end else if (CE) begin
      oe_ff <= nxt_oe;
      out_ff <= nxt_out;
      pi_ff <= nxt_pi;
    end
  end

  // flash pads: fixed function, no mode field
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      foe_ff <= 3'h0;
      fout_ff <= 3'h0;
    end else if (CE) begin
      foe_ff <= HIB_MODE ? 3'h0 : 3'h7;
      fout_ff <= {SERIAL_FLASH_SELECT_N | LOW_POWER_DEEP_SLEEP, FLASH_MOSI, FLASH_CLK};
    end
  end

  for (genvar g = 0; g < `PFM_NUM_PADS; g++) begin : g_cfg
    assign PAD_CFG[g] = '{drive: cfg_ff[g].drive, pull_up: cfg_ff[g].pull_up,
                          pull_down: cfg_ff[g].pull_down};
  end
  assign PAD_OE = oe_ff;
  assign PAD_OUT = out_ff;
  assign PERIPH_IN = pi_ff;
  assign FLASH_PAD_OE = foe_ff;
  assign FLASH_PAD_OUT = fout_ff;
  assign FLASH_MISO = pin_ff[11];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_wr_p3_pwm;
    PSEL && PENABLE && PWRITE && CE && PSTRB[0] && PADDR == `PFM_ADDR_PIN3 &&
    PWDATA[3:0] == `PFM_P3_PWM;
  endsequence
  sequence s_awake;
    CE && !HIB_MODE && !LOW_POWER_DEEP_SLEEP;
  endsequence

  tdi_reset_mode_a: assert property ($fell(RST) |-> cfg_ff[`PFM_IX_TDI].mode == `PFM_TDI_TDI)
    else $error("test-in pad not in mode 1 after reset");
  tdo_reset_mode_a: assert property ($fell(RST) |-> cfg_ff[`PFM_IX_TDO].mode == `PFM_TDO_TDO)
    else $error("test-out pad not in mode 1 after reset");
  gp_reset_hiz_a: assert property ($fell(RST) |-> PAD_OE == 11'h0 &&
    cfg_ff[`PFM_IX_P3].mode == `PFM_MODE_RESET_HIZ)
    else $error("general pad not floating after reset");
  flash_reset_hiz_a: assert property (disable iff (1'b0) RST |=> FLASH_PAD_OE == 3'h0)
    else $error("flash pad driven during reset");
  write_route_a: assert property (s_wr_p3_pwm ##1 s_awake |=>
    PAD_OE[`PFM_IX_P3] && PAD_OUT[`PFM_IX_P3] == $past(PERIPH_OUT.pwm_out_six))
    else $error("pin 3 not routed to pwm after write");
  unlisted_hiz_a: assert property (s_awake and
    cfg_ff[`PFM_IX_P3].mode == `PFM_MODE_RESET_HIZ |=> !PAD_OE[`PFM_IX_P3])
    else $error("unlisted mode drives pad");
  hib_float_a: assert property (CE && HIB_MODE && !cfg_ff[`PFM_IX_P4].hib_en
    |=> !PAD_OE[`PFM_IX_P4])
    else $error("pad driven in hibernate by default");
  tdo_hib_level_a: assert property (CE && HIB_MODE |=> PAD_OE[`PFM_IX_TDO] &&
    PAD_OUT[`PFM_IX_TDO] == $past(swd_ff))
    else $error("test-out hibernate level wrong");
  low_power_deep_sleep_tx_hold_a: assert property (CE && LOW_POWER_DEEP_SLEEP && !HIB_MODE &&
    cfg_ff[`PFM_IX_P9].mode == `PFM_P9_UTX |=> PAD_OE[`PFM_IX_P9] && PAD_OUT[`PFM_IX_P9])
    else $error("uart transmit not held high in deep sleep");
  flash_sel_hold_a: assert property (CE && LOW_POWER_DEEP_SLEEP |=> FLASH_PAD_OUT[2])
    else $error("flash select not held high in deep sleep");
  drive_code_a: assert property (PAD_CFG[`PFM_IX_P3].drive != `PFM_DRV_RSVD)
    else $error("reserved drive code on pad");
  pull_write_a: assert property (s_wr_p3_pwm and PSTRB[1] && PWDATA[`PFM_F_PULL_UP]
    |=> PAD_CFG[`PFM_IX_P3].pull_up)
    else $error("pull-up select not taken");
  strap_load_a: assert property ($rose(taken_ff) && !$past(ctrl_wr) |->
    swd_ff == strap_ff ##1 taken_ff)
    else $error("strap not loaded into debug mode");

endmodule
`default_nettype wire

// ===== verif/pfm_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfm_pad_model
  import pfm_pkg::*;
(
  // drives from the block
  input wire logic [10:0] PAD_OUT,
  input wire logic [10:0] PAD_OE,
  input wire pfm_pad_cfg_s [10:0] PAD_CFG,
  input wire logic [2:0] FLASH_PAD_OE,
  // levels back at the pads
  output logic [10:0] PAD_IN,
  output logic FLASH_PAD_MISO
);
  // undriven, unpulled pads toggle so a stale level never passes
  logic tog_ff = 1'b0;
  always #30 tog_ff = ~tog_ff;
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      if (PAD_OE[i]) PAD_IN[i] = PAD_OUT[i];
      else if (PAD_CFG[i].pull_up) PAD_IN[i] = 1'b1;
      else if (PAD_CFG[i].pull_down) PAD_IN[i] = 1'b0;
      else PAD_IN[i] = tog_ff;
    end
  end
  // a powered flash holds its data line high; a floating line toggles
  assign FLASH_PAD_MISO = FLASH_PAD_OE[2] ? 1'b1 : tog_ff;
endmodule
`default_nettype wire

// ===== verif/module_pad_function_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfm_defs.svh"
module module_pad_function_mux_tb
  import pfm_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic low_power_deep_sleep = 1'b0, hib = 1'b0, fsel_n = 1'b0, pready, pslverr, err, f_miso, fp_miso;
  logic strap = 1'b1;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  pfm_periph_out_s pout = '0;
  pfm_periph_in_s periph_in;
  logic [10:0] pad_in, pad_out, pad_oe;
  pfm_pad_cfg_s [10:0] pad_cfg;
  logic [2:0] fpo, fpoe;
  int errors = 0, n_checks = 0;
  pfm_pad_mux dut (
    .CLOCK(clock), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .LOW_POWER_DEEP_SLEEP(low_power_deep_sleep), .HIB_MODE(hib), .DEBUG_STRAP(strap),
    .PERIPH_OUT(pout), .PERIPH_IN(periph_in), .FLASH_CLK(1'b0), .FLASH_MOSI(1'b0),
    .SERIAL_FLASH_SELECT_N(fsel_n), .FLASH_MISO(f_miso), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_CFG(pad_cfg), .FLASH_PAD_OUT(fpo),
    .FLASH_PAD_OE(fpoe), .FLASH_PAD_MISO(fp_miso)
  );
  pfm_pad_model model (.PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_CFG(pad_cfg),
    .FLASH_PAD_OE(fpoe), .PAD_IN(pad_in), .FLASH_PAD_MISO(fp_miso));
  initial forever #10 clock = ~clock;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // slave may stretch the access; only the watchdog bounds the wait
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset;
    step(3);
    chk("flash oe in reset", 32'(fpoe), 32'h0);
    @(posedge clock);
    rst <= 1'b0;
    step(2);
    chk("pad oe after reset", 32'(pad_oe), 32'h400);
    apb(1'b0, `PFM_ADDR_TEST_IN, 32'h0);
    chk("test-in reg", rd, 32'h1);
    apb(1'b0, 32'h4402e0e8, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    apb(1'b0, `PFM_ADDR_STATUS, 32'h0);
    chk("strap status", rd, 32'h1);
    apb(1'b0, `PFM_ADDR_CTRL, 32'h0);
    chk("strap ctrl", rd, 32'h1);
    chk("flash data in", 32'(f_miso), 32'h1);
    $display("reset test done");
  endtask
  task automatic t_route;
    apb(1'b1, `PFM_ADDR_PIN3, 32'h133);
    pout.pwm_out_six <= 1'b1;
    step(1);
    chk("pin3 pwm", 32'({pad_oe[0], pad_out[0]}), 32'h3);
    chk("pin3 cfg", 32'(pad_cfg[0]), 32'ha);
    apb(1'b0, `PFM_ADDR_PIN3, 32'h0);
    chk("pin3 reg", rd, 32'h123);
    apb(1'b1, `PFM_ADDR_PIN3, 32'h2);
    step(1);
    chk("unlisted mode", 32'(pad_oe[0]), 32'h0);
    apb(1'b1, `PFM_ADDR_PIN4, 32'h207);
    step(6);
    chk("pin4 uart rx", 32'(periph_in.second_uart_receive), 32'h0);
    $display("route test done");
  endtask
  task automatic t_sleep;
    apb(1'b1, `PFM_ADDR_PIN9, 32'h7);
    apb(1'b1, `PFM_ADDR_PIN3, 32'h7);
    low_power_deep_sleep <= 1'b1;
    step(1);
    chk("sleep tx", 32'({pad_oe[0], pad_out[0]}), 32'h3);
    chk("sleep tx pin9", 32'({pad_oe[2], pad_out[2]}), 32'h3);
    chk("sleep select", 32'(fpo[2]), 32'h1);
    $display("sleep test done");
  endtask
  task automatic t_hib;
    apb(1'b1, `PFM_ADDR_CTRL, 32'h1);
    hib <= 1'b1;
    low_power_deep_sleep <= 1'b0;
    step(1);
    chk("hib float", 32'(pad_oe[0]), 32'h0);
    chk("hib tdo two-wire", 32'({pad_oe[10], pad_out[10]}), 32'h3);
    apb(1'b1, `PFM_ADDR_CTRL, 32'h0);
    step(1);
    chk("hib tdo four-wire", 32'({pad_oe[10], pad_out[10]}), 32'h2);
    $display("hibernate test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    give_verdict;
  end
  initial begin
    t_reset;
    t_route;
    t_sleep;
    t_hib;
    give_verdict;
  end
endmodule
`default_nettype wire
